// File: fpps_defines.svh
/*
  Constants of the forward PWM protection sequencer: timing figures,
  derived cycle counts, register offsets, field positions, reset values.
  Assumes a 100 MHz core clock.
*/
`ifndef FPPS_DEFINES_SVH
`define FPPS_DEFINES_SVH

// Clock
`define FPPS_CLK_PERIOD_NS 10
`define FPPS_CLK_MHZ 100

// Protection times in ns
`define FPPS_OC_WINDOW_NS 1500000
`define FPPS_OC_HICCUP_NS 40000000
`define FPPS_OV_SUSTAIN_NS 200000
`define FPPS_OV_HICCUP_NS 200000000
`define FPPS_OC_WINDOW_CYC (`FPPS_OC_WINDOW_NS / `FPPS_CLK_PERIOD_NS)
`define FPPS_OC_HICCUP_CYC (`FPPS_OC_HICCUP_NS / `FPPS_CLK_PERIOD_NS)
`define FPPS_OV_SUSTAIN_CYC (`FPPS_OV_SUSTAIN_NS / `FPPS_CLK_PERIOD_NS)
`define FPPS_OV_HICCUP_CYC (`FPPS_OV_HICCUP_NS / `FPPS_CLK_PERIOD_NS)

// Rectifier edge rate: 1.5 ns of edge per us
`define FPPS_RECT_STEP_PS 1500
`define FPPS_RECT_STEP_CYC \
  ((`FPPS_CLK_PERIOD_NS * 1000 * `FPPS_CLK_MHZ) / `FPPS_RECT_STEP_PS)

// Sequencing counts
`define FPPS_DUTY_LIMIT_SETTING_HITS 2'h3
`define FPPS_LOCK_EDGES 4'h8
`define FPPS_SYNC_TOL_PCT 10
`define FPPS_SS_PERIODS 8'h40
`define FPPS_DUTY_FULL 8'hFF

// Registers
`define FPPS_REG_CTRL 4'h0
`define FPPS_REG_STATUS 4'h4
`define FPPS_CTRL_EN_BIT 0
`define FPPS_CTRL_SYNC_BIT 1
`define FPPS_CTRL_RST 2'h0

`endif

// File: fpps_pkg.sv
/*
  Types of the forward PWM protection sequencer.
  Assumes fpps_defines.svh is compiled alongside.
*/
package fpps_pkg;

  typedef enum logic [2:0] {
    FPPS_IDLE = 3'b000,
    FPPS_SOFT = 3'b001,
    FPPS_RUN = 3'b010,
    FPPS_OC_HIC = 3'b011,
    FPPS_OV_HIC = 3'b100,
    FPPS_OT_OFF = 3'b101
  } fpps_mode_type;

  typedef struct packed {
    fpps_mode_type st;
    logic ctrl_en;
    logic ctrl_sync;
    logic [31:0] rdata;
    logic [15:0] pcnt;
    logic main_on;
    logic clamp_on;
    logic fwd_on;
    logic fw_on;
    logic [7:0] level;
    logic [7:0] ramp;
    logic hit_max;
    logic [1:0] duty_limit_setting_cnt;
    logic [7:0] ss_cnt;
    logic oc_active;
    logic [31:0] oc_cnt;
    logic [31:0] hic_cnt;
    logic [31:0] ov_cnt;
    logic ov_block;
    logic [15:0] rect_w;
    logic [15:0] step_cnt;
    logic sync_prev;
    logic [19:0] sync_meas;
    logic [3:0] lock_cnt;
    logic locked;
  } fpps_state_type;

endpackage : fpps_pkg

// File: fpps_power_stage_model.sv
/*
  Behavioural power stage and sync source for the PWM sequencer bench.
  Assumes the bench sets the compare delay and the sync half period.
*/
`timescale 1ns/100ps
module fpps_power_stage_model (
  // Clock
  input wire logic core_clk,
  // Gate from the sequencer
  input wire logic main_switch_gate,
  // Knobs from the bench
  input wire logic [15:0] on_cycles,
  input wire logic [15:0] sync_half,
  input wire logic sync_enable,
  // Flags back to the sequencer
  output logic current_compare,
  output logic sync_clock_in
);
  logic [15:0] on_cnt = 16'h0;
  logic [15:0] sync_cnt = 16'h0;
  logic sync_q = 1'b0;

  // Current ramps while the switch conducts; zero delay means never
  always @(posedge core_clk) begin
    on_cnt <= main_switch_gate ? on_cnt + 16'h1 : 16'h0;
  end
  assign current_compare = (on_cycles != 16'h0) && main_switch_gate &&
                           (on_cnt >= on_cycles);

  // Sync clock stands low when off; period set by the bench
  always @(posedge core_clk) begin
    if (!sync_enable) begin
      sync_cnt <= 16'h0;
      sync_q <= 1'b0;
    end else if (sync_cnt >= sync_half - 16'h1) begin
      sync_cnt <= 16'h0;
      sync_q <= !sync_q;
    end else begin
      sync_cnt <= sync_cnt + 16'h1;
    end
  end
  assign sync_clock_in = sync_q;
endmodule : fpps_power_stage_model

// File: fpps_sequencer.sv
/*
  Timing and fault sequencing of a peak-current-mode forward PWM
  controller: main/clamp gates, rectifier drives, sync lock, duty limit,
  current limit, overtemperature and overvoltage sequences.
  Assumes all inputs synchronous to core_clk and comparator flags
  already filtered; frequency_set_input holds the period in cycles (>=16).
*/
`timescale 1ns/100ps
`include "fpps_defines.svh"

// What this block does
// - Current compare ends main pulse next cycle
// - Control level sampled and forwarded continuously
// - Current limit trip truncates pulse next cycle
// - Run cycle-by-cycle limit for fixed interval
// - Interval expiry turns all drives off
// - Hiccup wait then fresh soft start
// - Short circuit handled like overcurrent
// - Overtemperature drives all gates low
// - Overtemperature clear restarts with soft start
// - On-time limited by duty limit setting
// - Duty limit also enforced during soft start
// - Three max-duty soft start periods start hiccup
// - Lock to sync within seven to ten periods
// - Internal oscillator used until lock
// - Sync outside ten percent window ignored
// - Sync accepted running or before soft start
// - Locked clock follows dithered sync per period up to the set period
// - Forward drive in phase, freewheel complementary
// - Slope ramp zero at start, rises linearly
// - Overvoltage turns all gates off immediately
// - Overvoltage clear: primary next period, rectifiers phase
// - Sustained overvoltage enters long hiccup wait
// - Rectifier edges move at fixed rate
module fpps_sequencer
  import fpps_pkg::*;
#(
  parameter int unsigned OC_WINDOW_CYC = `FPPS_OC_WINDOW_CYC,
  parameter int unsigned OC_HICCUP_CYC = `FPPS_OC_HICCUP_CYC,
  parameter int unsigned OV_SUSTAIN_CYC = `FPPS_OV_SUSTAIN_CYC,
  parameter int unsigned OV_HICCUP_CYC = `FPPS_OV_HICCUP_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  // Setup pins
  input wire logic [15:0] frequency_set_input,
  input wire logic [7:0] duty_limit_setting,
  input wire logic sync_clock_in,
  // Control level and comparator flags
  input wire logic [7:0] control_level,
  input wire logic current_compare,
  input wire logic current_limit_trip,
  input wire logic short_circuit_flag,
  input wire logic overtemp_flag,
  input wire logic overvoltage_sense,
  // Gate drives and analog references
  output logic main_switch_gate,
  output logic clamp_switch_gate,
  output logic forward_rectifier_drive,
  output logic freewheel_rectifier_drive,
  output logic [7:0] forwarded_level,
  output logic [7:0] slope_ramp
);

  // Longest on-time in cycles for the duty setting
  function automatic logic [15:0] fpps_duty_max(
    input logic [15:0] per,
    input logic [7:0] set
  );
    logic [23:0] frac;
    frac = per * set;
    if (set == `FPPS_DUTY_FULL) begin
      return per;
    end
    return {1'b0, per[15:1]} + frac[24-1:9];
  endfunction : fpps_duty_max

  // Sync period against the allowed window
  function automatic logic fpps_in_window(
    input logic [19:0] meas,
    input logic [15:0] per
  );
    logic [27:0] m;
    logic [27:0] p;
    m = meas * 28'(100);
    p = per * 28'(100 - `FPPS_SYNC_TOL_PCT);
    if (m < p) begin
      return 1'b0;
    end
    p = per * 28'(100 + `FPPS_SYNC_TOL_PCT);
    return m <= p;
  endfunction : fpps_in_window

  fpps_state_type s;
  fpps_state_type n;
  logic sync_rise;
  logic period_end;
  logic running;
  logic drive_ok;
  logic at_max;
  logic trip_any;
  logic faults_clear;
  logic [15:0] max_on;
  logic [15:0] per;

  // Next-state logic
  always_comb begin : next_state
    n = s;
    per = frequency_set_input;
    max_on = fpps_duty_max(per, duty_limit_setting);
    sync_rise = sync_clock_in & ~s.sync_prev;
    trip_any = current_limit_trip | short_circuit_flag;
    faults_clear = ~overtemp_flag & ~overvoltage_sense;
    running = (s.st == FPPS_SOFT) || (s.st == FPPS_RUN);
    n.level = control_level;
    n.sync_prev = sync_clock_in;
    n.rdata = 32'h0;
    // Register port
    if (reg_write && reg_addr == `FPPS_REG_CTRL) begin
      n.ctrl_en = reg_wdata[`FPPS_CTRL_EN_BIT];
      n.ctrl_sync = reg_wdata[`FPPS_CTRL_SYNC_BIT];
    end
    if (reg_read && reg_addr == `FPPS_REG_CTRL) begin
      n.rdata = {30'h0, s.ctrl_sync, s.ctrl_en};
    end
    if (reg_read && reg_addr == `FPPS_REG_STATUS) begin
      n.rdata = {24'h0, s.locked, s.ov_block, s.oc_active, 2'h0, s.st};
    end

    // Sync measurement and lock, in any mode
    if (sync_rise) begin
      n.sync_meas = 20'h1;
      if (s.ctrl_sync && fpps_in_window(s.sync_meas, per)) begin
        if (s.lock_cnt >= `FPPS_LOCK_EDGES - 4'h1) begin
          n.locked = 1'b1;
        end else begin
          n.lock_cnt = s.lock_cnt + 4'h1;
        end
      end else begin
        n.lock_cnt = 4'h0;
        n.locked = 1'b0;
      end
    end else if (!fpps_in_window(s.sync_meas, per) &&
                 s.sync_meas > 20'(per)) begin
      // Sync lost: fall back to the internal oscillator
      n.lock_cnt = 4'h0;
      n.locked = 1'b0;
      n.sync_meas = 20'h0;
    end else if (s.sync_meas != 20'h0) begin
      n.sync_meas = s.sync_meas + 20'h1;
    end

    // Period boundary: sync edge or internal count once locked, else internal count
    if (s.locked) begin
      period_end = sync_rise || s.pcnt >= per - 16'h1;
    end else begin
      period_end = s.pcnt >= per - 16'h1;
    end
    n.pcnt = period_end ? 16'h0 : s.pcnt + 16'h1;
    n.ramp = 8'((32'(n.pcnt) * 32'hFF) / 32'(per));
    // Overcurrent interval and overvoltage duration timers
    if (running && trip_any) begin
      n.oc_active = 1'b1;
    end
    if (s.oc_active) begin
      n.oc_cnt = s.oc_cnt + 32'h1;
    end
    n.ov_cnt = overvoltage_sense ? s.ov_cnt + 32'h1 : 32'h0;
    n.hic_cnt = s.hic_cnt + 32'h1;
    // Mode sequencing
    case (s.st)
      FPPS_IDLE: begin
        if (s.ctrl_en && faults_clear) begin
          n.st = FPPS_SOFT;
        end
      end
      FPPS_SOFT, FPPS_RUN: begin
        if (period_end) begin
          n.ss_cnt = s.ss_cnt + 8'h1;
          if (s.st == FPPS_SOFT && s.ss_cnt >= `FPPS_SS_PERIODS) begin
            n.st = FPPS_RUN;
          end
          if (s.st == FPPS_SOFT) begin
            n.duty_limit_setting_cnt = s.hit_max ? s.duty_limit_setting_cnt + 2'h1 : 2'h0;
            if (s.hit_max && s.duty_limit_setting_cnt == `FPPS_DUTY_LIMIT_SETTING_HITS - 2'h1) begin
              n.st = FPPS_OC_HIC;
              n.hic_cnt = 32'h0;
            end
          end
        end
        if (s.oc_active && s.oc_cnt >= OC_WINDOW_CYC - 1) begin
          n.st = FPPS_OC_HIC;
          n.hic_cnt = 32'h0;
        end
        if (s.ov_cnt >= OV_SUSTAIN_CYC - 1 && overvoltage_sense) begin
          n.st = FPPS_OV_HIC;
          n.hic_cnt = 32'h0;
        end
      end
      FPPS_OC_HIC: begin
        if (s.hic_cnt >= OC_HICCUP_CYC - 1 && faults_clear) begin
          n.st = FPPS_SOFT;
        end
      end
      FPPS_OV_HIC: begin
        if (s.hic_cnt >= OV_HICCUP_CYC - 1 && faults_clear) begin
          n.st = FPPS_SOFT;
        end
      end
      FPPS_OT_OFF: begin
        if (faults_clear) begin
          n.st = FPPS_SOFT;
        end
      end
      default: begin
        n.st = FPPS_IDLE;
      end
    endcase
    // Overtemperature overrides every mode but idle; disable overrides every mode
    if (overtemp_flag && s.st != FPPS_IDLE) begin
      n.st = FPPS_OT_OFF;
    end
    if (!s.ctrl_en) begin
      n.st = FPPS_IDLE;
    end

    // Fresh soft start clears the protection counters
    if (n.st == FPPS_SOFT && s.st != FPPS_SOFT) begin
      n.oc_active = 1'b0;
      n.oc_cnt = 32'h0;
      n.duty_limit_setting_cnt = 2'h0;
      n.ss_cnt = 8'h0;
      n.hit_max = 1'b0;
    end
    if (n.st != FPPS_SOFT && n.st != FPPS_RUN) begin
      n.oc_active = 1'b0;
      n.oc_cnt = 32'h0;
    end

    // Overvoltage blanks drives until the next period start
    if (overvoltage_sense) begin
      n.ov_block = 1'b1;
    end else if (period_end) begin
      n.ov_block = 1'b0;
    end

    drive_ok = (n.st == FPPS_SOFT || n.st == FPPS_RUN) &&
               !n.ov_block && !overtemp_flag;
    // Main switch: on at period start, off on compare, limit or max duty
    at_max = 17'(s.pcnt) + 17'h1 >= 17'(max_on);
    if (!drive_ok) begin
      n.main_on = 1'b0;
    end else if (period_end) begin
      n.main_on = max_on != 16'h0;
      n.hit_max = 1'b0;
    end else if (s.main_on && (current_compare || trip_any)) begin
      n.main_on = 1'b0;
    end else if (s.main_on && at_max) begin
      n.main_on = 1'b0;
      n.hit_max = 1'b1;
    end
    if (period_end && !drive_ok) begin
      n.hit_max = 1'b0;
    end

    // Clamp covers the off interval
    n.clamp_on = drive_ok && !n.main_on;
    // Rectifier width ramps from zero at a fixed edge rate
    if (!drive_ok) begin
      n.rect_w = 16'h0;
      n.step_cnt = 16'h0;
    end else if (s.step_cnt >= 16'(`FPPS_RECT_STEP_CYC - 1)) begin
      n.step_cnt = 16'h0;
      if (s.rect_w < per) begin
        n.rect_w = s.rect_w + 16'h1;
      end
    end else begin
      n.step_cnt = s.step_cnt + 16'h1;
    end

    // Forward with main gate, freewheel in the off interval
    n.fwd_on = drive_ok && n.main_on && n.pcnt < s.rect_w;
    n.fw_on = drive_ok && !n.main_on &&
              17'(n.pcnt) + 17'(s.rect_w) >= 17'(per);
  end : next_state

  // State register
  always_ff @(posedge core_clk or negedge reset_n) begin : state_reg
    if (!reset_n) begin
      s <= '0;
      s.st <= FPPS_IDLE;
      s.ctrl_en <= 1'(`FPPS_CTRL_RST >> `FPPS_CTRL_EN_BIT);
    end else begin
      s <= n;
    end
  end : state_reg

  // Outputs straight from flip-flops
  assign reg_rdata = s.rdata;
  assign main_switch_gate = s.main_on;
  assign clamp_switch_gate = s.clamp_on;
  assign forward_rectifier_drive = s.fwd_on;
  assign freewheel_rectifier_drive = s.fw_on;
  assign forwarded_level = s.level;
  assign slope_ramp = s.ramp;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  // Compare during a pulse ends it next cycle
  property p_compare_ends;
    s.main_on && current_compare && !period_end |=> !s.main_on;
  endproperty
  a_compare_ends: assert property (p_compare_ends)
    else $error("main pulse outlived current compare");
  property p_level_fwd;
    ##1 forwarded_level == $past(control_level);
  endproperty
  a_level_fwd: assert property (p_level_fwd)
    else $error("control level not forwarded");
  property p_trip_ends;
    s.main_on && trip_any && !period_end |=> !main_switch_gate;
  endproperty
  a_trip_ends: assert property (p_trip_ends)
    else $error("limit trip did not truncate pulse");
  sequence s_oc_expiry;
    running && s.oc_active && s.oc_cnt >= OC_WINDOW_CYC - 1 &&
      !overtemp_flag && s.ctrl_en;
  endsequence
  property p_oc_shutdown;
    s_oc_expiry |=> (s.st == FPPS_OC_HIC || s.st == FPPS_OV_HIC) &&
      !main_switch_gate && !clamp_switch_gate &&
      !forward_rectifier_drive && !freewheel_rectifier_drive;
  endproperty
  a_oc_shutdown: assert property (p_oc_shutdown)
    else $error("drives not off after current limit interval");
  property p_ot_off;
    overtemp_flag |=> !main_switch_gate && !clamp_switch_gate &&
      !forward_rectifier_drive && !freewheel_rectifier_drive;
  endproperty
  a_ot_off: assert property (p_ot_off)
    else $error("gate high during overtemperature");
  property p_ot_restart;
    s.st == FPPS_OT_OFF && faults_clear && s.ctrl_en && !overtemp_flag
      |=> s.st == FPPS_SOFT;
  endproperty
  a_ot_restart: assert property (p_ot_restart)
    else $error("no soft start after overtemperature");
  property p_max_duty;
    main_switch_gate |-> s.pcnt < max_on;
  endproperty
  a_max_duty: assert property (p_max_duty)
    else $error("on-time beyond duty limit");
  property p_fwd_phase;
    forward_rectifier_drive |-> main_switch_gate && !clamp_switch_gate;
  endproperty
  a_fwd_phase: assert property (p_fwd_phase)
    else $error("forward drive out of phase");
  property p_ov_off;
    overvoltage_sense |=> !main_switch_gate && !clamp_switch_gate &&
      !forward_rectifier_drive && !freewheel_rectifier_drive;
  endproperty
  a_ov_off: assert property (p_ov_off)
    else $error("gate high during overvoltage");
  sequence s_ov_release;
    s.ov_block ##1 !s.ov_block;
  endsequence
  property p_ov_phase_in;
    s_ov_release |-> s.rect_w == 16'h0 && s.pcnt == 16'h0;
  endproperty
  a_ov_phase_in: assert property (p_ov_phase_in)
    else $error("overvoltage release not at period start");
  property p_rect_rate;
    s.rect_w != $past(s.rect_w) && s.rect_w != 16'h0
      |-> s.rect_w == $past(s.rect_w) + 16'h1 && s.step_cnt == 16'h0;
  endproperty
  a_rect_rate: assert property (p_rect_rate)
    else $error("rectifier width jumped");
  property p_clean_start;
    s.st == FPPS_SOFT && $past(s.st) != FPPS_SOFT
      |-> s.oc_cnt == 32'h0 && s.duty_limit_setting_cnt == 2'h0 && !s.oc_active;
  endproperty
  a_clean_start: assert property (p_clean_start)
    else $error("soft start entered with stale counters");

endmodule : fpps_sequencer

// File: fpps_sequencer_test.sv
/*
  Self-checking bench of the PWM protection sequencer.
  Assumes shortened protection counts and a 40-cycle switching period.
*/
`timescale 1ns/100ps
module fpps_sequencer_test;
  localparam int PER = 40;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [31:0] reg_rdata;
  logic [7:0] duty = 8'h00;
  logic [7:0] level = 8'h00;
  logic trip = 1'b0;
  logic short_flag = 1'b0;
  logic ot = 1'b0;
  logic ov = 1'b0;
  logic [15:0] on_cycles = 16'h5;
  logic [15:0] sync_half = 16'h14;
  logic sync_on = 1'b0;
  logic cmp, sync, main_g, clamp_g, fwd_g, fw_g;
  logic [7:0] fwd_level, ramp;
  int fails = 0;
  int compares = 0;
  wire [3:0] gates = {main_g, clamp_g, fwd_g, fw_g};

  fpps_sequencer #(.OC_WINDOW_CYC(200), .OC_HICCUP_CYC(300),
    .OV_SUSTAIN_CYC(50), .OV_HICCUP_CYC(400)) i_fpps_sequencer (
    .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .frequency_set_input(16'h28),
    .duty_limit_setting(duty), .sync_clock_in(sync),
    .control_level(level), .current_compare(cmp),
    .current_limit_trip(trip), .short_circuit_flag(short_flag),
    .overtemp_flag(ot), .overvoltage_sense(ov),
    .main_switch_gate(main_g), .clamp_switch_gate(clamp_g),
    .forward_rectifier_drive(fwd_g), .freewheel_rectifier_drive(fw_g),
    .forwarded_level(fwd_level), .slope_ramp(ramp));

  fpps_power_stage_model i_fpps_power_stage_model (
    .core_clk(core_clk), .main_switch_gate(main_g),
    .on_cycles(on_cycles), .sync_half(sync_half), .sync_enable(sync_on),
    .current_compare(cmp), .sync_clock_in(sync));

  // Clock
  initial begin
    forever #5 core_clk = ~core_clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  task automatic ran_out;
    fails++;
    $display("wait ran out at %0t", $time);
    tally_and_finish();
  endtask : ran_out

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : reg_rd

  // Poll the mode field until it matches, bounded
  task automatic wait_mode(input logic [2:0] m, input int bound,
                           output logic [31:0] s);
    for (int i = 0; i < bound; i++) begin
      reg_rd(4'h4, s);
      if (s[2:0] === m) return;
    end
    ran_out();
  endtask : wait_mode

  // Length of the next full main pulse in cycles
  task automatic width(output int w);
    int i;
    for (i = 0; i < 300 && main_g !== 1'b0; i++) cyc(1);
    for (i = 0; i < 300 && main_g !== 1'b1; i++) cyc(1);
    if (i == 300) ran_out();
    w = 0;
    while (main_g === 1'b1 && w < 300) begin
      w++;
      cyc(1);
    end
  endtask : width

  // Wait for the next rise of the main gate or the sync clock, bounded
  task automatic rise_of(input bit use_sync);
    int i;
    for (i = 0; i < 300 && (use_sync ? sync : main_g) !== 1'b0; i++)
      cyc(1);
    for (i = 0; i < 300 && (use_sync ? sync : main_g) !== 1'b1; i++)
      cyc(1);
    if (i == 300) ran_out();
  endtask : rise_of

  task automatic t_reset;
    logic [31:0] s;
    check(gates, 4'h0);
    reg_rd(4'h0, s);
    check(s, 32'h0);
    reg_rd(4'hC, s);
    check(s, 32'h0);
    reg_wr(4'h4, 32'h7);
    reg_rd(4'h4, s);
    check(s[2:0], 3'h0);
    reg_wr(4'h0, 32'h1);
    wait_mode(3'h1, 4, s);
    check(s[2:0], 3'h1);
    $display("test reset done");
  endtask : t_reset

  task automatic t_level;
    @(posedge core_clk);
    level <= 8'h5A;
    #1;
    check(fwd_level, 8'h00);
    cyc(1);
    check(fwd_level, 8'h5A);
    $display("test level done");
  endtask : t_level

  // Open loop soft start: duty clamp, then three hits force hiccup
  task automatic t_softmax;
    logic [31:0] s;
    int w;
    on_cycles <= 16'h0;
    for (int k = 0; k < 2; k++) begin
      duty <= k ? 8'h80 : 8'h00;
      width(w);
      check(w, k ? 30 : 20);
      wait_mode(3'h3, 100, s);
      check(s[2:0], 3'h3);
      cyc(2);
      check(gates, 4'h0);
      wait_mode(3'h1, 400, s);
      check(s[5], 1'b0);
    end
    on_cycles <= 16'h5;
    duty <= 8'h00;
    $display("test soft start limit done");
  endtask : t_softmax

  task automatic t_trip(input bit use_short);
    logic [31:0] s;
    int w;
    realtime t0;
    wait_mode(3'h2, 2000, s);
    width(w);
    check(w < PER / 2, 1'b1);
    t0 = $realtime;
    if (use_short) short_flag <= 1'b1;
    else trip <= 1'b1;
    width(w);
    check(w <= 2, 1'b1);
    reg_rd(4'h4, s);
    check({s[5], s[2:0]}, 4'hA);
    wait_mode(3'h3, 200, s);
    check($realtime - t0 >= 2000.0, 1'b1);
    cyc(1);
    check(gates, 4'h0);
    trip <= 1'b0;
    short_flag <= 1'b0;
    wait_mode(3'h1, 400, s);
    check(s[2:0], 3'h1);
    $display("test current limit done");
  endtask : t_trip

  task automatic t_ot;
    logic [31:0] s;
    wait_mode(3'h2, 2000, s);
    ot <= 1'b1;
    cyc(3);
    check(gates, 4'h0);
    reg_rd(4'h4, s);
    check(s[2:0], 3'h5);
    ot <= 1'b0;
    wait_mode(3'h1, 20, s);
    check(s[2:0], 3'h1);
    $display("test overtemp done");
  endtask : t_ot

  task automatic t_ov;
    logic [31:0] s;
    int w;
    wait_mode(3'h2, 2000, s);
    ov <= 1'b1;
    cyc(3);
    check(gates, 4'h0);
    cyc(10);
    ov <= 1'b0;
    width(w);
    check(w > 0 && w < PER / 2, 1'b1);
    ov <= 1'b1;
    cyc(120);
    wait_mode(3'h4, 20, s);
    check(s[2:0], 3'h4);
    check(gates, 4'h0);
    ov <= 1'b0;
    wait_mode(3'h1, 400, s);
    $display("test overvoltage done");
  endtask : t_ov

  task automatic t_sync;
    logic [31:0] s;
    reg_wr(4'h0, 32'h3);
    sync_half <= 16'h14;
    sync_on <= 1'b1;
    cyc(PER * 2);
    reg_rd(4'h4, s);
    check(s[7], 1'b0);
    cyc(PER * 10);
    reg_rd(4'h4, s);
    check(s[7], 1'b1);
    // Shorter sync period inside the window: period follows each edge
    sync_half <= 16'h13;
    cyc(PER * 2);
    rise_of(1'b1);
    check(main_g, 1'b0);
    cyc(1);
    check({main_g, ramp}, 9'h100);
    reg_rd(4'h4, s);
    check(s[7], 1'b1);
    sync_half <= 16'h1A;
    cyc(PER * 12);
    reg_rd(4'h4, s);
    check(s[7], 1'b0);
    sync_on <= 1'b0;
    $display("test sync done");
  endtask : t_sync

  // Ramp, clamp and rectifier drives after a fresh phase-in
  task automatic t_drives;
    ov <= 1'b1;
    cyc(2);
    ov <= 1'b0;
    rise_of(1'b0);
    check({main_g, fwd_g, ramp}, 10'h200);
    cyc(1400);
    rise_of(1'b0);
    check({clamp_g, fwd_g, ramp}, 10'h100);
    cyc(2);
    check({main_g, fwd_g, ramp}, 10'h20C);
    cyc(36);
    check({main_g, clamp_g, fw_g, ramp}, 11'h3F2);
    $display("test drives done");
  endtask : t_drives

  // Main sequence
  initial begin
    repeat (20) @(posedge core_clk);
    reset_n <= 1'b1;
    cyc(1);
    t_reset();
    t_level();
    t_softmax();
    t_trip(1'b0);
    t_trip(1'b1);
    t_ot();
    t_ov();
    t_sync();
    t_drives();
    tally_and_finish();
  end
endmodule : fpps_sequencer_test
